// ---- rtl/slec_pkg.sv ----
// lookup engine control package: offsets, reset values, field layouts
// assumes 12-bit byte addressing and 8-bit registers on the host port
package slec_pkg;

    // =========================================================
    // bus and widths
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 8;
    localparam int NUM_PORTS = 7;
    localparam int INDEX_W   = 10;
    localparam int AGE_W     = 11;

    // =========================================================
    // register offsets
    localparam logic [11:0] OFS_CTRL_A     = 12'h310;
    localparam logic [11:0] OFS_CTRL_B     = 12'h311;
    localparam logic [11:0] OFS_CTRL_C     = 12'h312;
    localparam logic [11:0] OFS_AGE_PERIOD = 12'h313;

    // =========================================================
    // reset values
    localparam logic [7:0] RST_CTRL_A      = 8'h61;
    localparam logic [7:0] RST_CTRL_B      = 8'h0c;
    localparam logic [1:0] RST_FLUSH_SCOPE = 2'h0;
    localparam logic [7:0] RST_AGE_PERIOD  = 8'h4b;

    // =========================================================
    // field layouts and codes
    localparam int FLUSH_SCOPE_LSB = 2;
    localparam int MAC_MCAST_BIT   = 40;

    localparam logic [1:0] HASH_CRC = 2'h1;
    localparam logic [1:0] HASH_XOR = 2'h2;

    localparam logic [1:0] SCOPE_NONE   = 2'h0;
    localparam logic [1:0] SCOPE_DYN    = 2'h1;
    localparam logic [1:0] SCOPE_STATIC = 2'h2;
    localparam logic [1:0] SCOPE_BOTH   = 2'h3;

    // crc-10 generator polynomial and seed for the table index hash
    localparam logic [9:0] CRC_POLY = 10'h233;
    localparam logic [9:0] CRC_SEED = 10'h3ff;

    typedef struct packed {
        logic       vlan_en;
        logic       drop_invalid;
        logic [2:0] age_count;
        logic       rsvd_mcast_en;
        logic [1:0] dynamic_index_select;
    } slec_ctrl_a_t;

    typedef struct packed {
        logic unicast_learn_dis;
        logic self_filter_en;
        logic flush_all;
        logic flush_mstp;
        logic mcast_sa_forward;
        logic aging_en;
        logic fast_aging;
        logic link_down_flush;
    } slec_ctrl_b_t;

    typedef struct packed {
        logic valid;
        logic drop;
        logic to_host;
        logic learn;
    } slec_verdict_t;

    typedef enum logic {FL_IDLE, FL_BUSY} slec_flush_state_t;

endpackage : slec_pkg

// ---- rtl/slec_top.sv ----
// lookup engine control registers and the decisions they steer
// assumes packet, link and flush inputs come from logic on CLK
//
// Overview of operation
// - control a bit 7 is the vlan master enable, resets off.
// - bit 6 set drops invalid vlan id packets, clear sends them to host.
// - enabled unknown vlan id forwarding overrides the bit 6 choice.
// - bits 5:3 age count, reset 100, copied into updated dynamic entries.
// - aging time equals age count times age period seconds, period 0x4b.
// - bit 2 enables reserved multicast table lookups, resets off.
// - index select 00 or 11 uses ten low destination address bits.
// - index select 01 uses crc hash, 10 xor hash, resets 01.
// - control b bit 7 set stops unicast source learning, resets 0.
// - self filter drops packets whose source equals the switch address.
// - self filter acts only on ports with their own enable set.
// - writing 1 to bit 5 starts a self-clearing table flush.
// - both flush triggers remove only entries of the chosen scope.
// - flush scope 00 none, 01 dynamic, 10 static, 11 both.
// - writing 1 to bit 4 flushes matching spanning tree entries.
// - bit 3 set forwards multicast source packets, clear drops; reset 1.
// - bit 2 enables table aging, resets on.
// - bit 1 enables fast aging, resets off.
// - bit 0 set makes a port link loss flush that port's entries.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module slec_top
    import slec_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 ARST_N,
    input  wire logic [ADDR_W-1:0]    ADDR,
    input  wire logic [DATA_W-1:0]    WR_DATA,
    input  wire logic                 WR_STB,
    input  wire logic                 RD_STB,
    output logic      [DATA_W-1:0]    RD_DATA,
    input  wire logic [47:0]          SWITCH_MAC,
    input  wire logic                 PKT_VALID,
    input  wire logic [47:0]          PKT_SRC_MAC,
    input  wire logic [47:0]          PKT_DST_MAC,
    input  wire logic                 PKT_SELF_FILTER_EN,
    input  wire logic                 PKT_VID_INVALID,
    input  wire logic                 UNKNOWN_VID_FWD_EN,
    output slec_verdict_t             VERDICT,
    output logic      [INDEX_W-1:0]   DYN_INDEX,
    output logic                      VLAN_ENABLE,
    output logic                      RSVD_MCAST_EN,
    output logic      [2:0]           AGE_COUNT,
    output logic      [AGE_W-1:0]     AGE_TIME_SEC,
    output logic                      AGING_EN,
    output logic                      FAST_AGING,
    input  wire logic [NUM_PORTS-1:0] LINK_UP,
    output logic      [NUM_PORTS-1:0] LINK_FLUSH_PORTS,
    output logic                      FLUSH_REQ,
    output logic                      FLUSH_MSTP_ONLY,
    output logic                      FLUSH_DYNAMIC,
    output logic                      FLUSH_STATIC,
    input  wire logic                 FLUSH_DONE
);

    // =========================================================
    // declarations
    slec_ctrl_a_t      ctrl_a;
    slec_ctrl_b_t      ctrl_b;
    logic [1:0]        flush_scope;
    logic [7:0]        age_period;
    slec_flush_state_t flush_state;
    logic              cur_all;
    logic [NUM_PORTS-1:0] link_prev;

    logic wr_a;
    logic wr_b;
    logic wr_c;
    logic wr_p;
    logic set_all;
    logic set_mstp;
    logic clr_all;
    logic clr_mstp;
    logic start_flush;
    logic self_hit;
    logic mcast_sa;
    logic vid_drop;
    logic vid_host;
    logic next_drop;
    logic [INDEX_W-1:0] next_index;

    assign wr_a = WR_STB && (ADDR == OFS_CTRL_A);
    assign wr_b = WR_STB && (ADDR == OFS_CTRL_B);
    assign wr_c = WR_STB && (ADDR == OFS_CTRL_C);
    assign wr_p = WR_STB && (ADDR == OFS_AGE_PERIOD);

    // =========================================================
    // hash functions
    function automatic logic [INDEX_W-1:0] slec_crc10(
        input logic [47:0] d
    );
        logic [9:0] c;
        logic       fb;
        c = CRC_SEED;
        fb = 1'b0;
        for (int i = 47; i >= 0; i--) begin
            fb = c[9] ^ d[i];
            c  = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
        end
        return c;
    endfunction : slec_crc10

    function automatic logic [INDEX_W-1:0] slec_xor10(
        input logic [47:0] d
    );
        return d[9:0] ^ d[19:10] ^ d[29:20] ^ d[39:30]
               ^ {2'h0, d[47:40]};
    endfunction : slec_xor10

    // =========================================================
    // control register a
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_a <= slec_ctrl_a_t'(RST_CTRL_A);
        end else if (wr_a) begin
            ctrl_a <= slec_ctrl_a_t'(WR_DATA);
        end
    end

    // =========================================================
    // control register b, one process owns the whole struct
    // self-clearing flush triggers; a new write wins over completion
    assign set_all  = wr_b && WR_DATA[5];
    assign set_mstp = wr_b && WR_DATA[4];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_b <= slec_ctrl_b_t'(RST_CTRL_B);
        end else begin
            if (wr_b) begin
                ctrl_b.unicast_learn_dis <= WR_DATA[7];
                ctrl_b.self_filter_en    <= WR_DATA[6];
                ctrl_b.mcast_sa_forward  <= WR_DATA[3];
                ctrl_b.aging_en          <= WR_DATA[2];
                ctrl_b.fast_aging        <= WR_DATA[1];
                ctrl_b.link_down_flush   <= WR_DATA[0];
            end
            ctrl_b.flush_all  <= (ctrl_b.flush_all && !clr_all)
                                 || set_all;
            ctrl_b.flush_mstp <= (ctrl_b.flush_mstp && !clr_mstp)
                                 || set_mstp;
        end
    end

    // =========================================================
    // control register c and age period
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flush_scope <= RST_FLUSH_SCOPE;
        end else if (wr_c) begin
            flush_scope <= WR_DATA[FLUSH_SCOPE_LSB +: 2];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            age_period <= RST_AGE_PERIOD;
        end else if (wr_p) begin
            age_period <= WR_DATA;
        end
    end

    // =========================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RD_DATA <= 8'h00;
        end else if (RD_STB) begin
            case (ADDR)
                OFS_CTRL_A:     RD_DATA <= ctrl_a;
                OFS_CTRL_B:     RD_DATA <= ctrl_b;
                OFS_CTRL_C:     RD_DATA <= {4'h0, flush_scope, 2'h0};
                OFS_AGE_PERIOD: RD_DATA <= age_period;
                default:        RD_DATA <= 8'h00;
            endcase
        end else begin
            RD_DATA <= 8'h00;
        end
    end

    // =========================================================
    // flush sequencer
    // a full flush is served first; a pending stp flush follows it
    assign start_flush = (flush_state == FL_IDLE)
                         && (ctrl_b.flush_all || ctrl_b.flush_mstp);

    always_comb begin
        clr_all  = 1'b0;
        clr_mstp = 1'b0;
        if (start_flush && flush_scope == SCOPE_NONE) begin
            // empty scope: nothing can be removed, finish at once
            clr_all  = ctrl_b.flush_all;
            clr_mstp = ctrl_b.flush_mstp;
        end else if (flush_state == FL_BUSY && FLUSH_DONE) begin
            clr_all  = cur_all;
            clr_mstp = !cur_all;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flush_state     <= FL_IDLE;
            cur_all         <= 1'b0;
            FLUSH_REQ       <= 1'b0;
            FLUSH_MSTP_ONLY <= 1'b0;
            FLUSH_DYNAMIC   <= 1'b0;
            FLUSH_STATIC    <= 1'b0;
        end else begin
            case (flush_state)
                FL_IDLE: begin
                    if (start_flush && flush_scope != SCOPE_NONE) begin
                        flush_state     <= FL_BUSY;
                        cur_all         <= ctrl_b.flush_all;
                        FLUSH_REQ       <= 1'b1;
                        FLUSH_MSTP_ONLY <= !ctrl_b.flush_all;
                        FLUSH_DYNAMIC   <= (flush_scope == SCOPE_DYN)
                            || (flush_scope == SCOPE_BOTH);
                        FLUSH_STATIC    <= (flush_scope == SCOPE_STATIC)
                            || (flush_scope == SCOPE_BOTH);
                    end
                end
                FL_BUSY: begin
                    if (FLUSH_DONE) begin
                        flush_state     <= FL_IDLE;
                        FLUSH_REQ       <= 1'b0;
                        FLUSH_MSTP_ONLY <= 1'b0;
                        FLUSH_DYNAMIC   <= 1'b0;
                        FLUSH_STATIC    <= 1'b0;
                    end
                end
                default: begin
                    flush_state <= FL_IDLE;
                    FLUSH_REQ   <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // link down flush
    // previous state resets to down so reset never looks like a drop
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            link_prev        <= '0;
            LINK_FLUSH_PORTS <= '0;
        end else begin
            link_prev        <= LINK_UP;
            LINK_FLUSH_PORTS <= ctrl_b.link_down_flush
                                ? (link_prev & ~LINK_UP)
                                : '0;
        end
    end

    // =========================================================
    // packet verdict
    assign mcast_sa = PKT_SRC_MAC[MAC_MCAST_BIT];
    assign self_hit = ctrl_b.self_filter_en && PKT_SELF_FILTER_EN
                      && (PKT_SRC_MAC == SWITCH_MAC);
    // unknown vid forwarding owns the packet when it is on
    assign vid_drop = ctrl_a.vlan_en && PKT_VID_INVALID
                      && !UNKNOWN_VID_FWD_EN
                      && ctrl_a.drop_invalid;
    assign vid_host = ctrl_a.vlan_en && PKT_VID_INVALID
                      && !UNKNOWN_VID_FWD_EN
                      && !ctrl_a.drop_invalid;
    assign next_drop = self_hit || vid_drop
                       || (mcast_sa && !ctrl_b.mcast_sa_forward);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            VERDICT <= '0;
        end else begin
            VERDICT.valid   <= PKT_VALID;
            VERDICT.drop    <= PKT_VALID && next_drop;
            VERDICT.to_host <= PKT_VALID && !next_drop && vid_host;
            VERDICT.learn   <= PKT_VALID && !next_drop && !mcast_sa
                               && !ctrl_b.unicast_learn_dis;
        end
    end

    // =========================================================
    // dynamic table index
    always_comb begin
        case (ctrl_a.dynamic_index_select)
            HASH_CRC: next_index = slec_crc10(PKT_DST_MAC);
            HASH_XOR: next_index = slec_xor10(PKT_DST_MAC);
            default:  next_index = PKT_DST_MAC[INDEX_W-1:0];
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DYN_INDEX <= '0;
        end else begin
            DYN_INDEX <= next_index;
        end
    end

    // =========================================================
    // aging and table settings toward the lookup engine
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AGE_TIME_SEC <= '0;
        end else begin
            AGE_TIME_SEC <= AGE_W'(ctrl_a.age_count)
                            * AGE_W'(age_period);
        end
    end

    assign VLAN_ENABLE   = ctrl_a.vlan_en;
    assign RSVD_MCAST_EN = ctrl_a.rsvd_mcast_en;
    assign AGE_COUNT     = ctrl_a.age_count;
    assign AGING_EN      = ctrl_b.aging_en;
    assign FAST_AGING    = ctrl_b.fast_aging;

endmodule : slec_top

// ---- dv/slec_top_sva.sv ----
// checker for the lookup engine control registers
// assumes it is bound to slec_top and sees only its ports
`timescale 1ns/1ps

module slec_top_sva
    import slec_pkg::*;
(
    input wire logic                 CLK,
    input wire logic                 ARST_N,
    input wire logic [ADDR_W-1:0]    ADDR,
    input wire logic [DATA_W-1:0]    WR_DATA,
    input wire logic                 WR_STB,
    input wire logic                 PKT_VALID,
    input wire logic [47:0]          PKT_SRC_MAC,
    input wire slec_verdict_t        VERDICT,
    input wire logic                 VLAN_ENABLE,
    input wire logic                 RSVD_MCAST_EN,
    input wire logic [2:0]           AGE_COUNT,
    input wire logic                 AGING_EN,
    input wire logic                 FAST_AGING,
    input wire logic [NUM_PORTS-1:0] LINK_UP,
    input wire logic [NUM_PORTS-1:0] LINK_FLUSH_PORTS,
    input wire logic                 FLUSH_REQ,
    input wire logic                 FLUSH_MSTP_ONLY,
    input wire logic                 FLUSH_DYNAMIC,
    input wire logic                 FLUSH_STATIC,
    input wire logic                 FLUSH_DONE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    // =========================================================
    // register fields follow the writes
    property p_vlan;
        WR_STB && ADDR == OFS_CTRL_A |=> VLAN_ENABLE == $past(WR_DATA[7]);
    endproperty
    a_vlan: assert property (p_vlan)
        else $error("vlan enable does not follow write");
    property p_age;
        WR_STB && ADDR == OFS_CTRL_A |=> AGE_COUNT == $past(WR_DATA[5:3]);
    endproperty
    a_age: assert property (p_age)
        else $error("age count does not follow write");
    property p_rsvd;
        WR_STB && ADDR == OFS_CTRL_A |=> RSVD_MCAST_EN == $past(WR_DATA[2]);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved multicast enable does not follow write");
    property p_aging;
        WR_STB && ADDR == OFS_CTRL_B |=> AGING_EN == $past(WR_DATA[2]);
    endproperty
    a_aging: assert property (p_aging)
        else $error("aging enable does not follow write");
    property p_fast;
        WR_STB && ADDR == OFS_CTRL_B |=> FAST_AGING == $past(WR_DATA[1]);
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast aging does not follow write");

    // =========================================================
    // flush, link and verdict relations
    property p_flush_hold;
        FLUSH_REQ && !FLUSH_DONE |=> FLUSH_REQ
            && $stable({FLUSH_MSTP_ONLY, FLUSH_DYNAMIC, FLUSH_STATIC});
    endproperty
    a_flush_hold: assert property (p_flush_hold)
        else $error("flush request changed before completion");
    property p_flush_end;
        FLUSH_REQ && FLUSH_DONE |=> !FLUSH_REQ;
    endproperty
    a_flush_end: assert property (p_flush_end)
        else $error("flush request stays after completion");
    property p_scope;
        FLUSH_REQ |-> FLUSH_DYNAMIC || FLUSH_STATIC;
    endproperty
    a_scope: assert property (p_scope)
        else $error("flush request with empty scope");
    property p_link;
        |LINK_FLUSH_PORTS |-> (LINK_FLUSH_PORTS
            & ~($past(LINK_UP, 2) & ~$past(LINK_UP))) == '0;
    endproperty
    a_link: assert property (p_link)
        else $error("link flush for a port whose link did not fall");
    property p_mc_learn;
        PKT_VALID && PKT_SRC_MAC[MAC_MCAST_BIT] |=> !VERDICT.learn;
    endproperty
    a_mc_learn: assert property (p_mc_learn)
        else $error("multicast source was learned");
endmodule : slec_top_sva

bind slec_top slec_top_sva i_sva (
    .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .PKT_VALID(PKT_VALID), .PKT_SRC_MAC(PKT_SRC_MAC),
    .VERDICT(VERDICT), .VLAN_ENABLE(VLAN_ENABLE),
    .RSVD_MCAST_EN(RSVD_MCAST_EN), .AGE_COUNT(AGE_COUNT),
    .AGING_EN(AGING_EN), .FAST_AGING(FAST_AGING), .LINK_UP(LINK_UP),
    .LINK_FLUSH_PORTS(LINK_FLUSH_PORTS), .FLUSH_REQ(FLUSH_REQ),
    .FLUSH_MSTP_ONLY(FLUSH_MSTP_ONLY), .FLUSH_DYNAMIC(FLUSH_DYNAMIC),
    .FLUSH_STATIC(FLUSH_STATIC), .FLUSH_DONE(FLUSH_DONE));

// ---- dv/tb.sv ----
// self-checking bench for the lookup engine control registers
// assumes slec_top on a 25 MHz clock, host port driven from here
`timescale 1ns/1ps

module tb
    import slec_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  q;
    } slec_tb_row_t;

    logic                 clk = 1'b0, arst_n = 1'b0;
    logic [ADDR_W-1:0]    addr = '0;
    logic [7:0]           wr_data = '0, q;
    logic                 wr_stb = 1'b0, rd_stb = 1'b0, pkt_valid = 1'b0;
    logic [47:0]          src = '0, dst = 48'h0123_4567_89ab;
    logic [47:0]          mac = 48'h0a0b_0c0d_0e0f;
    logic                 self_en = 1'b0, vid_inv = 1'b0, unk_en = 1'b0;
    logic                 flush_done = 1'b0;
    logic [NUM_PORTS-1:0] link_up = 7'h7f, link_flush;
    logic [7:0]           rd_data;
    slec_verdict_t        verdict;
    logic [9:0]           dyn_index;
    logic [2:0]           age_count;
    logic [10:0]          age_time;
    logic                 vlan_en, rsvd_en, aging_en, fast_aging;
    logic                 flush_req, mstp_only, flush_dyn, flush_static;
    int                   n_fail = 0, samples_checked = 0;
    slec_tb_row_t rows [7] = '{'{12'h310, 8'h80, 8'h80},
        '{12'h310, 8'h3e, 8'h3e}, '{12'h311, 8'hcf, 8'hcf},
        '{12'h311, 8'h0c, 8'h0c}, '{12'h312, 8'hff, 8'h0c},
        '{12'h313, 8'h10, 8'h10}, '{12'h314, 8'hff, 8'h00}};

    always #20 clk = ~clk;

    slec_top i_dut (
        .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WR_DATA(wr_data),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
        .SWITCH_MAC(mac), .PKT_VALID(pkt_valid), .PKT_SRC_MAC(src),
        .PKT_DST_MAC(dst), .PKT_SELF_FILTER_EN(self_en),
        .PKT_VID_INVALID(vid_inv), .UNKNOWN_VID_FWD_EN(unk_en),
        .VERDICT(verdict), .DYN_INDEX(dyn_index), .VLAN_ENABLE(vlan_en),
        .RSVD_MCAST_EN(rsvd_en), .AGE_COUNT(age_count),
        .AGE_TIME_SEC(age_time), .AGING_EN(aging_en),
        .FAST_AGING(fast_aging), .LINK_UP(link_up),
        .LINK_FLUSH_PORTS(link_flush), .FLUSH_REQ(flush_req),
        .FLUSH_MSTP_ONLY(mstp_only), .FLUSH_DYNAMIC(flush_dyn),
        .FLUSH_STATIC(flush_static), .FLUSH_DONE(flush_done));

    // =========================================================
    // bus, packet and compare tasks
    task automatic chk(input string nm, input logic [47:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk);
        wr_stb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    task automatic pkt(input logic [47:0] s, input logic pe, vi, ue,
                       input logic [3:0] e);
        @(posedge clk);
        pkt_valid <= 1'b1;
        src       <= s;
        self_en   <= pe;
        vid_inv   <= vi;
        unk_en    <= ue;
        @(posedge clk);
        pkt_valid <= 1'b0;
        #1 chk("verdict", verdict, e);
    endtask : pkt

    function automatic logic [9:0] idx(input logic [47:0] d,
                                       input logic [1:0] s);
        logic [9:0] c;
        logic       fb;
        c = CRC_SEED;
        for (int i = 47; i >= 0; i--) begin
            fb = c[9] ^ d[i];
            c  = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
        end
        if (s == HASH_CRC) return c;
        if (s == HASH_XOR) return d[9:0] ^ d[19:10] ^ d[29:20]
                                  ^ d[39:30] ^ {2'h0, d[47:40]};
        return d[9:0];
    endfunction : idx

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // =========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL_A, q);
        chk("ctrl_a_reset", q, RST_CTRL_A);
        rd(OFS_CTRL_B, q);
        chk("ctrl_b_reset", q, RST_CTRL_B);
        rd(OFS_AGE_PERIOD, q);
        chk("period_reset", q, 8'h4b);
        chk("age_time_reset", age_time, 11'h12c);
        chk("fields_reset", {vlan_en, rsvd_en, age_count, aging_en,
            fast_aging}, 7'h12);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            chk("reg_read", q, rows[i].q);
        end
        $display("test registers done");
        wr(OFS_CTRL_A, 8'h79);
        wr(OFS_AGE_PERIOD, 8'h10);
        repeat (2) @(posedge clk);
        #1 chk("age_count", age_count, 3'h7);
        chk("age_time", age_time, 11'h070);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CTRL_A, 8'h64 | 8'(s));
            @(posedge clk);
            #1 chk("dyn_index", dyn_index, idx(dst, 2'(s)));
            chk("rsvd_en", rsvd_en, 1'b1);
        end
        $display("test index done");
        wr(OFS_CTRL_B, 8'h44);
        wr(OFS_CTRL_A, 8'hc1); // no vlan table to fill here
        pkt(mac, 1'b1, 1'b0, 1'b0, 4'hc);
        pkt(mac, 1'b0, 1'b0, 1'b0, 4'h9);
        pkt(48'h0100_0000_0001, 1'b0, 1'b0, 1'b0, 4'hc);
        pkt(48'h0200_0000_0001, 1'b0, 1'b1, 1'b0, 4'hc);
        pkt(48'h0200_0000_0001, 1'b0, 1'b1, 1'b1, 4'h9);
        wr(OFS_CTRL_B, 8'h0c);
        pkt(mac, 1'b1, 1'b0, 1'b0, 4'h9);
        wr(OFS_CTRL_A, 8'h81);
        pkt(48'h0200_0000_0001, 1'b0, 1'b1, 1'b0, 4'hb);
        wr(OFS_CTRL_B, 8'h8c);
        pkt(48'h0200_0000_0001, 1'b0, 1'b0, 1'b0, 4'h8);
        pkt(48'h0100_0000_0001, 1'b0, 1'b0, 1'b0, 4'h8);
        wr(OFS_CTRL_A, 8'h41);
        pkt(48'h0200_0000_0001, 1'b0, 1'b1, 1'b0, 4'h8);
        $display("test verdict done");
        for (int s = 1; s < 4; s++) begin
            wr(OFS_CTRL_C, 8'(s << 2));
            wr(OFS_CTRL_B, (s == 2) ? 8'h1c : 8'h2c);
            @(posedge clk);
            #1 chk("flush_req", flush_req, 1'b1);
            chk("flush_kind", {mstp_only, flush_static, flush_dyn},
                {s == 2, 2'(s)});
            rd(OFS_CTRL_B, q);
            chk("trigger_busy", q[5:4], (s == 2) ? 2'h1 : 2'h2);
            @(posedge clk) flush_done <= 1'b1;
            @(posedge clk) flush_done <= 1'b0;
            #1 chk("flush_end", flush_req, 1'b0);
            rd(OFS_CTRL_B, q);
            chk("trigger_clear", q[5:4], 2'h0);
        end
        wr(OFS_CTRL_C, 8'h00);
        wr(OFS_CTRL_B, 8'h2c);
        @(posedge clk);
        #1 chk("flush_none", flush_req, 1'b0);
        rd(OFS_CTRL_B, q);
        chk("none_clear", q[5:4], 2'h0);
        $display("test flush done");
        for (int en = 0; en < 2; en++) begin
            wr(OFS_CTRL_B, 8'h0c | 8'(en));
            @(posedge clk) link_up <= 7'h77;
            @(posedge clk);
            #1 chk("link_flush", link_flush, en ? 7'h08 : 7'h00);
            @(posedge clk) link_up <= 7'h7f;
        end
        $display("test link done");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule : tb
